// ### rtl/gate_mode_pkg.sv
// shared constants, types and register map for the barrier gate mode control
package gate_mode_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned FAIL_DELAY_S = 5;
    localparam int unsigned CLEAR_HOLD_S = 2;
    localparam int unsigned FAIL_DELAY_CYC = FAIL_DELAY_S * CLK_HZ;
    localparam int unsigned CLEAR_HOLD_CYC = CLEAR_HOLD_S * CLK_HZ;
    localparam int unsigned SEC_CYC = CLK_HZ;
    localparam logic [3:0] RAMP_DEF = 4'h3;
    localparam logic [3:0] RAMP_MIN = 4'h1;
    localparam logic [3:0] RAMP_MAX = 4'ha;
    localparam logic [5:0] TX_MAX = 6'h28;
    // register byte offsets
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_RAMP = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CYCLES = 8'h0c;
    localparam logic [7:0] REG_SERVICE = 8'h10;
    localparam logic [7:0] REG_CURRENT = 8'h14;
    localparam logic [7:0] REG_ENROL = 8'h18;
    localparam logic [7:0] REG_CMD = 8'h1c;
    localparam logic [7:0] REG_DIGITS = 8'h20;
    // cfg field positions
    localparam int unsigned CFG_PWR_LSB = 0;
    localparam int unsigned CFG_STAGGER = 2;
    localparam int unsigned CFG_LOOP_LSB = 3;
    localparam int unsigned CFG_TAILGATE = 5;
    localparam int unsigned CFG_RADIO = 6;
    localparam int unsigned CFG_AUTOCLOSE = 7;
    localparam int unsigned CFG_MOTOR = 8;
    localparam int unsigned CFG_PAIRED = 9;
    localparam int unsigned CFG_SVC_LSB = 10;
    localparam logic [31:0] CFG_RESET = 32'h0000_0040;
    // cmd bits
    localparam int unsigned CMD_FACTORY = 0;
    localparam int unsigned CMD_SVC_CLR = 1;
    localparam int unsigned CMD_SHOW = 2;
    localparam int unsigned CMD_TX_ADD = 3;
    localparam int unsigned CMD_TX_DEL = 4;
    localparam int unsigned CMD_OBS_ADD = 5;
    localparam int unsigned CMD_OBS_DEL = 6;

    typedef enum logic [1:0] {
        PWR_FAIL_SAFE = 2'b00,
        PWR_FAIL_SECURE = 2'b01,
        PWR_OPEN_NOW = 2'b10,
        PWR_CLOSE_NOW = 2'b11
    } pwr_mode_t;

    typedef enum logic [1:0] {
        LOOP_HOLD = 2'b00,
        LOOP_TALLY = 2'b01,
        LOOP_FULL_OPEN = 2'b10
    } loop_mode_t;

    typedef enum logic [1:0] {
        OBS_OPEN = 2'b00,
        OBS_CLOSE = 2'b01,
        OBS_REVERSE = 2'b10,
        OBS_STOP = 2'b11
    } obs_role_t;

    typedef struct packed {
        logic mains_ok;
        logic batt_low;
        logic open_hold;
        logic exit_loop;
        logic at_open;
        logic at_closed;
        logic opening;
        logic closing;
        logic confirm_key;
        logic partner_act;
        logic local_act;
    } gate_in_t;

    typedef struct packed {
        logic cmd_open;
        logic cmd_close;
        logic cmd_stop;
        logic halted;
        logic partner_req;
        logic service_due_indicator;
        logic ramp_active;
    } gate_out_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;
endpackage

// ### rtl/gate_mode_ctrl.sv
// barrier gate mode control: power failure, ramp, cycle counts, loop modes, enrolment, pairing
`timescale 1ns/1ps
`default_nettype none
module gate_mode_ctrl
    import gate_mode_pkg::*;
#(
    parameter int unsigned FAIL_CYC = FAIL_DELAY_CYC,
    parameter int unsigned HOLD_CYC = CLEAR_HOLD_CYC,
    parameter int unsigned TICK_CYC = SEC_CYC
) (
    input wire logic sys_clk, // system clock, 25 MHz
    input wire logic sys_rst, // synchronous reset, active high
    input wire gate_mode_pkg::wb_req_t wb_req, // wishbone request
    output gate_mode_pkg::wb_rsp_t wb_rsp, // wishbone answer
    input wire gate_mode_pkg::gate_in_t pins_in, // raw pins and motor status
    output gate_mode_pkg::gate_out_t gate_out // gate commands and indicators
);
    import gate_mode_pkg::*;

    if (FAIL_CYC < 1 || HOLD_CYC < 1 || TICK_CYC < 1) begin
        $error("gate_mode_ctrl: counts must be at least one cycle");
    end

    // pins: three-stage sync, change accepted when stages two and three agree
    gate_in_t s1_q, s2_q, s3_q, in_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            in_q <= '0;
        end else begin
            s1_q <= pins_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            in_q <= gate_in_t'((s2_q & s3_q) | (in_q & (s2_q | s3_q)));
        end
    end
    gate_in_t prev_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) prev_q <= '0;
        else prev_q <= in_q;
    end

    // registers
    logic [31:0] cfg_q, cmd_dat_q;
    logic [3:0] ramp_q;
    logic [15:0] cur_open_q, cur_close_q;
    logic [31:0] cycles_q, svc_cnt_q;
    logic [5:0] tx_cnt_q;
    logic [1:0] obs_cnt_q;
    obs_role_t obs_role_q [2];
    logic svc_flag_q, ack_q;
    logic [31:0] rdat_q;

    wire pwr_mode_t pwr_mode = pwr_mode_t'(cfg_q[CFG_PWR_LSB +: 2]);
    wire loop_mode_t loop_mode = loop_mode_t'(cfg_q[CFG_LOOP_LSB +: 2]);
    wire stagger_en = cfg_q[CFG_STAGGER];
    wire tailgate_en = cfg_q[CFG_TAILGATE];
    wire radio_en = cfg_q[CFG_RADIO];
    wire auto_close = cfg_q[CFG_AUTOCLOSE];
    wire paired_gate_setting = cfg_q[CFG_PAIRED];
    wire [1:0] svc_sel = cfg_q[CFG_SVC_LSB +: 2];

    wire bus_req = wb_req.cyc && wb_req.stb && !ack_q;
    wire wr = bus_req && wb_req.we && (wb_req.sel == 4'hf);
    wire wr_cfg = wr && wb_req.adr == REG_CFG;
    wire wr_ramp = wr && wb_req.adr == REG_RAMP;
    wire wr_cur = wr && wb_req.adr == REG_CURRENT;
    wire wr_cmd = wr && wb_req.adr == REG_CMD;
    wire [31:0] wdat = wb_req.dat;
    wire [3:0] ramp_new = (wdat[3:0] < RAMP_MIN) ? RAMP_MIN : ((wdat[3:0] > RAMP_MAX) ? RAMP_MAX : wdat[3:0]);
    wire ramp_change = wr_ramp && ramp_new != ramp_q;
    wire factory = wr_cmd && wdat[CMD_FACTORY];
    wire enrol_visible = radio_en && tx_cnt_q < TX_MAX;
    wire delete_visible = radio_en && tx_cnt_q != 6'h00;
    wire obs_add_ok = radio_en && obs_cnt_q < 2'h2;
    wire tx_add = wr_cmd && wdat[CMD_TX_ADD] && enrol_visible;
    wire tx_del = wr_cmd && wdat[CMD_TX_DEL] && delete_visible;
    wire obs_add = wr_cmd && wdat[CMD_OBS_ADD] && obs_add_ok;
    wire obs_del = wr_cmd && wdat[CMD_OBS_DEL] && radio_en && obs_cnt_q != 2'h0;

    // service threshold select: 0=10k default, 1=5k, 2=15k, 3=25k
    function automatic logic [31:0] svc_limit(input logic [1:0] s);
        case (s)
            2'h1: svc_limit = 32'd5000;
            2'h2: svc_limit = 32'd15000;
            2'h3: svc_limit = 32'd25000;
            default: svc_limit = 32'd10000;
        endcase
    endfunction

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfg_q <= CFG_RESET;
            ramp_q <= RAMP_DEF;
        end else if (factory) begin
            cfg_q <= (CFG_RESET & ~(32'h1 << CFG_MOTOR)) | (cfg_q & (32'h1 << CFG_MOTOR));
            ramp_q <= RAMP_DEF;
        end else begin
            if (wr_cfg) cfg_q <= wdat;
            if (wr_ramp) ramp_q <= ramp_new;
        end
    end

    // current thresholds kept through factory restore unless the restore changes the ramp back to its default
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cur_open_q <= 16'h0000;
            cur_close_q <= 16'h0000;
        end else if (ramp_change || (factory && ramp_q != RAMP_DEF)) begin
            cur_open_q <= 16'h0000;
            cur_close_q <= 16'h0000;
        end else if (wr_cur) begin
            cur_open_q <= wdat[15:0];
            cur_close_q <= wdat[31:16];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_cnt_q <= 6'h00;
            obs_cnt_q <= 2'h0;
            obs_role_q[0] <= OBS_OPEN;
            obs_role_q[1] <= OBS_OPEN;
        end else begin
            if (tx_add) tx_cnt_q <= tx_cnt_q + 6'h01;
            else if (tx_del) tx_cnt_q <= wdat[8] ? 6'h00 : tx_cnt_q - 6'h01;
            if (obs_add) begin
                obs_role_q[obs_cnt_q[0]] <= obs_role_t'(wdat[17:16]);
                obs_cnt_q <= obs_cnt_q + 2'h1;
            end else if (obs_del) begin
                obs_cnt_q <= wdat[8] ? 2'h0 : obs_cnt_q - 2'h1;
            end
        end
    end

    // cycle counting: a cycle completes on arrival at closed after having been fully open
    logic been_open_q;
    wire arrive_closed = in_q.at_closed && !prev_q.at_closed;
    wire cycle_done = arrive_closed && been_open_q;
    logic show_q;
    logic [31:0] hold_cnt_q;
    wire hold_done = show_q && in_q.confirm_key && hold_cnt_q == HOLD_CYC - 1;
    wire svc_clr = wr_cmd && wdat[CMD_SVC_CLR];
    wire svc_zero = hold_done || svc_clr;
    // flag judged on the next count, so a clear is not undone by the old count
    wire [31:0] svc_cnt_d = svc_zero ? {31'h0, cycle_done} : svc_cnt_q + {31'h0, cycle_done};
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            been_open_q <= 1'b0;
            hold_cnt_q <= '0;
            show_q <= 1'b0;
        end else begin
            if (in_q.at_open) been_open_q <= 1'b1;
            else if (arrive_closed) been_open_q <= 1'b0;
            if (wr_cmd) show_q <= wdat[CMD_SHOW];
            if (!(show_q && in_q.confirm_key) || hold_done) hold_cnt_q <= '0;
            else hold_cnt_q <= hold_cnt_q + 32'h1;
        end
    end
    // a completing cycle in the clear cycle counts from zero: the set wins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cycles_q <= '0;
            svc_cnt_q <= '0;
            svc_flag_q <= 1'b0;
        end else begin
            if (hold_done) cycles_q <= {31'h0, cycle_done};
            else if (cycle_done) cycles_q <= cycles_q + 32'h1;
            svc_cnt_q <= svc_cnt_d;
            if (svc_cnt_d > svc_limit(svc_sel)) svc_flag_q <= 1'b1;
            else if (svc_zero) svc_flag_q <= 1'b0;
        end
    end

    // digit scroll: two decimal digits per second from the left of eight
    logic [31:0] bcd_q;
    logic [1:0] pair_q;
    logic [31:0] tick_q;
    logic [7:0] digits_q;
    function automatic logic [31:0] to_bcd(input logic [31:0] v);
        logic [31:0] r;
        logic [31:0] t;
        r = '0;
        t = v;
        for (int i = 0; i < 8; i++) begin
            r[i*4 +: 4] = 4'(t % 32'd10);
            t = t / 32'd10;
        end
        to_bcd = r;
    endfunction
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bcd_q <= '0;
            pair_q <= 2'h0;
            tick_q <= '0;
            digits_q <= 8'h00;
        end else begin
            bcd_q <= to_bcd(cycles_q);
            tick_q <= (!show_q || tick_q == TICK_CYC - 1) ? 32'h0 : tick_q + 32'h1;
            if (!show_q) pair_q <= 2'h0;
            else if (tick_q == TICK_CYC - 1) pair_q <= pair_q + 2'h1;
            digits_q <= show_q ? bcd_q[(3 - pair_q) * 8 +: 8] : 8'h00;
        end
    end

    // power failure handling
    logic [31:0] fail_cnt_q;
    logic halt_q;
    logic fail_done_q;
    wire low_fail = !in_q.mains_ok && in_q.batt_low;
    // one command per outage: a held command would keep restarting the drive's travel
    wire fail_timed = !stagger_en && low_fail && fail_cnt_q == FAIL_CYC && !fail_done_q;
    wire mains_fell = !in_q.mains_ok && prev_q.mains_ok;
    wire recovered = (in_q.mains_ok && !prev_q.mains_ok) || (!in_q.batt_low && prev_q.batt_low);
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fail_cnt_q <= '0;
            halt_q <= 1'b0;
            fail_done_q <= 1'b0;
        end else begin
            if (!low_fail) fail_done_q <= 1'b0;
            else if (fail_timed) fail_done_q <= 1'b1;
            if (!low_fail) fail_cnt_q <= '0;
            else if (fail_cnt_q != FAIL_CYC) fail_cnt_q <= fail_cnt_q + 32'h1;
            if (in_q.mains_ok) halt_q <= 1'b0;
            else if (mains_fell && (pwr_mode == PWR_OPEN_NOW || pwr_mode == PWR_CLOSE_NOW)) halt_q <= 1'b1;
        end
    end
    wire fs_open = fail_timed && pwr_mode == PWR_FAIL_SAFE && !in_q.at_open;
    wire fs_close = fail_timed && pwr_mode == PWR_FAIL_SECURE && !in_q.at_closed;
    wire im_open = mains_fell && pwr_mode == PWR_OPEN_NOW && !in_q.at_open;
    wire im_close = mains_fell && pwr_mode == PWR_CLOSE_NOW && !in_q.at_closed;
    wire resume_close = recovered && in_q.mains_ok | !in_q.batt_low && auto_close && in_q.at_open
        && (pwr_mode == PWR_FAIL_SAFE || pwr_mode == PWR_OPEN_NOW);

    // loop modes
    logic [15:0] tally_q;
    logic full_open_q;
    wire hold_rise = in_q.open_hold && !prev_q.open_hold;
    wire hold_fall = !in_q.open_hold && prev_q.open_hold;
    wire exit_rise = in_q.exit_loop && !prev_q.exit_loop;
    wire exit_seen = exit_rise && !(tailgate_en && in_q.closing);
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tally_q <= 16'h0000;
            full_open_q <= 1'b0;
        end else begin
            if (loop_mode != LOOP_TALLY) tally_q <= 16'h0000;
            else if (hold_rise && !exit_seen) tally_q <= tally_q + 16'h0001;
            else if (exit_seen && !hold_rise && tally_q != 16'h0000) tally_q <= tally_q - 16'h0001;
            if (loop_mode != LOOP_FULL_OPEN || in_q.at_closed) full_open_q <= 1'b0;
            else if (in_q.at_open && in_q.open_hold) full_open_q <= 1'b1;
        end
    end
    // edges only: a level would reload the drive every cycle and the arm would never arrive
    wire loop_open = (hold_rise && !in_q.at_open)
        || (loop_mode == LOOP_HOLD && in_q.open_hold && in_q.closing && !prev_q.closing);
    wire loop_close = (loop_mode == LOOP_HOLD && hold_fall && (in_q.opening || in_q.at_open))
        || (loop_mode == LOOP_TALLY && exit_seen && tally_q == 16'h0001)
        || (loop_mode == LOOP_FULL_OPEN && hold_fall && full_open_q);
    wire exit_stop = exit_rise && in_q.closing && !tailgate_en;

    // outputs
    logic open_q, close_q, stop_q, partner_q, ramp_on_q;
    wire normal = !halt_q;
    wire act_local = in_q.local_act && !prev_q.local_act;
    wire partner_rise = in_q.partner_act && !prev_q.partner_act;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            open_q <= 1'b0;
            close_q <= 1'b0;
            stop_q <= 1'b0;
            partner_q <= 1'b0;
            ramp_on_q <= 1'b0;
        end else begin
            open_q <= fs_open || im_open || (normal && (loop_open || (partner_rise && paired_gate_setting)));
            close_q <= fs_close || im_close || (normal && (loop_close || resume_close) && !in_q.open_hold);
            stop_q <= normal && exit_stop;
            partner_q <= paired_gate_setting && act_local;
            ramp_on_q <= cfg_q[CFG_MOTOR] && (in_q.at_open || in_q.at_closed);
        end
    end
    assign gate_out.cmd_open = open_q;
    assign gate_out.cmd_close = close_q;
    assign gate_out.cmd_stop = stop_q;
    assign gate_out.halted = halt_q;
    assign gate_out.partner_req = partner_q;
    assign gate_out.service_due_indicator = svc_flag_q;
    assign gate_out.ramp_active = ramp_on_q;

    // wishbone slave: one wait state, unmapped reads zero
    wire [31:0] status_w = {16'h0, tally_q[7:0], obs_cnt_q, halt_q, svc_flag_q,
        delete_visible, enrol_visible, show_q, 1'b0};
    wire [31:0] rd_mux = (wb_req.adr == REG_CFG) ? cfg_q
        : (wb_req.adr == REG_RAMP) ? {28'h0, ramp_q}
        : (wb_req.adr == REG_STATUS) ? status_w
        : (wb_req.adr == REG_CYCLES) ? cycles_q
        : (wb_req.adr == REG_SERVICE) ? svc_cnt_q
        : (wb_req.adr == REG_CURRENT) ? {cur_close_q, cur_open_q}
        : (wb_req.adr == REG_ENROL) ? {22'h0, obs_role_q[1], obs_role_q[0], tx_cnt_q}
        : (wb_req.adr == REG_DIGITS) ? {24'h0, digits_q}
        : 32'h0;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            rdat_q <= '0;
        end else begin
            ack_q <= bus_req;
            if (bus_req) rdat_q <= rd_mux;
        end
    end
    assign wb_rsp.ack = ack_q;
    assign wb_rsp.dat = rdat_q;

    // checks
    fail_open_delay_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        fs_open |=> open_q) else $error("fail-safe open not issued");
    fail_close_delay_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        fs_close |=> close_q) else $error("fail-secure close not issued");
    stagger_block_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        stagger_en |-> !fail_timed) else $error("power response while stagger enabled");
    halt_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        halt_q && !in_q.mains_ok |=> halt_q) else $error("halt released without mains");
    ramp_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ramp_q >= RAMP_MIN && ramp_q <= RAMP_MAX) else $error("ramp outside range");
    ramp_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ramp_change |=> cur_open_q == 16'h0 && cur_close_q == 16'h0) else $error("current not zeroed");
    count_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hold_done && !cycle_done |=> cycles_q == 32'h0 && !svc_flag_q) else $error("count clear incomplete");
    tx_limit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tx_cnt_q <= TX_MAX) else $error("transmitter store overflow");
    tailgate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tailgate_en |=> !stop_q) else $error("exit loop acted while ignored");
    fail_once_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        fail_timed |=> !fail_timed) else $error("power response repeated");
    hold_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        loop_mode == LOOP_HOLD && hold_fall && in_q.at_open && normal |=> close_q) else $error("hold release missed");
    exit_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        exit_rise && in_q.closing && !tailgate_en && normal |=> stop_q) else $error("exit loop did not stop arm");
    close_now_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        im_close |=> close_q && halt_q) else $error("close-immediate not issued");
endmodule
`default_nettype wire

// ### test/gate_drive_model.sv
// motor drive stand-in: travels between the limits on open and close pulses
`timescale 1ns/1ps
`default_nettype none
module gate_drive_model #(parameter int TRAVEL = 8) (
    input wire logic sys_clk, // system clock
    input wire logic sys_rst, // sync reset, active high
    input wire logic cmd_open, // open pulse
    input wire logic cmd_close, // close pulse
    input wire logic cmd_stop, // stop pulse
    output logic at_open, // full open limit
    output logic at_closed, // full closed limit
    output logic opening, // moving up
    output logic closing // moving down
);
    int cnt_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            {at_open, at_closed, opening, closing} <= 4'b0100;
            cnt_q <= 0;
        end else if (cmd_stop) begin
            opening <= 1'b0;
            closing <= 1'b0;
        end else if (cmd_open && !at_open) begin
            {at_open, at_closed, opening, closing} <= 4'b0010;
            cnt_q <= TRAVEL;
        end else if (cmd_close && !at_closed) begin
            {at_open, at_closed, opening, closing} <= 4'b0001;
            cnt_q <= TRAVEL;
        end else if ((opening || closing) && cnt_q == 1) begin
            // limits are reached only at the end of a full travel
            {at_open, at_closed, opening, closing} <= {opening, closing, 2'b00};
            cnt_q <= 0;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
endmodule
`default_nettype wire

// ### test/barrier_gate_mode_control_tb_top.sv
// self-checking bench for the barrier gate mode control
`timescale 1ns/1ps
`default_nettype none
module barrier_gate_mode_control_tb_top;
    import gate_mode_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    wb_req_t wb_req = '0;
    wb_rsp_t wb_rsp;
    gate_in_t pins_in;
    gate_out_t gate_out;
    logic mains_ok = 1'b1, batt_low = 1'b0, local_act = 1'b0;
    logic open_hold = 1'b0, exit_loop = 1'b0, confirm_key = 1'b0;
    logic at_open, at_closed, opening, closing;
    int fails = 0, n_tests = 0, n_open = 0, n_close = 0, n_partner = 0, n_stop = 0;
    logic [31:0] rd;

    gate_mode_ctrl #(.FAIL_CYC(20), .HOLD_CYC(10), .TICK_CYC(4)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .wb_req(wb_req), .wb_rsp(wb_rsp), .pins_in(pins_in), .gate_out(gate_out));
    gate_drive_model #(.TRAVEL(16)) drive_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_open(gate_out.cmd_open),
        .cmd_close(gate_out.cmd_close), .cmd_stop(gate_out.cmd_stop), .at_open(at_open),
        .at_closed(at_closed), .opening(opening), .closing(closing));

    // the partner controller's activation input stays idle
    always_comb pins_in = '{mains_ok: mains_ok, batt_low: batt_low, open_hold: open_hold, exit_loop: exit_loop,
        at_open: at_open, at_closed: at_closed, opening: opening, closing: closing,
        confirm_key: confirm_key, partner_act: 1'b0, local_act: local_act};

    initial forever #20 sys_clk = ~sys_clk;

    // pulse tallies let scenarios judge one-cycle outputs without racing them
    always @(posedge sys_clk) begin
        n_open <= n_open + (gate_out.cmd_open === 1'b1);
        n_close <= n_close + (gate_out.cmd_close === 1'b1);
        n_partner <= n_partner + (gate_out.partner_req === 1'b1);
        n_stop <= n_stop + (gate_out.cmd_stop === 1'b1);
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat);
        int k;
        k = 0;
        @(posedge sys_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: wdat};
        do begin
            @(posedge sys_clk);
            k++;
        end while (wb_rsp.ack !== 1'b1 && k < 50);
        rd = wb_rsp.dat;
        if (k >= 50) chk("wb ack", 32'h1, 32'h0);
        wb_req <= '0;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic test_regs();
        wb_xfer(1'b0, REG_CFG, 32'h0);
        chk("cfg reset", CFG_RESET, rd);
        wb_xfer(1'b0, REG_RAMP, 32'h0);
        chk("ramp reset", 32'h0000_0003, rd);
        wb_xfer(1'b1, REG_RAMP, 32'h0000_000b);
        wb_xfer(1'b0, REG_RAMP, 32'h0);
        chk("ramp upper clamp", 32'h0000_000a, rd);
        wb_xfer(1'b0, REG_CURRENT, 32'h0);
        chk("currents after ramp change", 32'h0, rd);
        wb_xfer(1'b1, REG_RAMP, 32'h0);
        wb_xfer(1'b0, REG_RAMP, 32'h0);
        chk("ramp lower clamp", 32'h0000_0001, rd);
        wb_xfer(1'b0, 8'h3c, 32'h0);
        chk("unmapped read", 32'h0, rd);
        $display("test_regs done");
    endtask

    task automatic test_open_now();
        int c0;
        c0 = n_open;
        wb_xfer(1'b1, REG_CFG, 32'h0000_0442);
        mains_ok <= 1'b0;
        wait_cyc(12);
        chk("open pulses on mains loss", c0 + 1, n_open);
        chk("halted while mains absent", 32'h1, {31'h0, gate_out.halted});
        mains_ok <= 1'b1;
        wait_cyc(12);
        chk("halt released on mains", 32'h0, {31'h0, gate_out.halted});
        $display("test_open_now done");
    endtask

    task automatic test_fail_secure();
        int c0;
        c0 = n_close;
        wb_xfer(1'b1, REG_CFG, 32'h0000_0445);
        mains_ok <= 1'b0;
        batt_low <= 1'b1;
        wait_cyc(40);
        chk("no close while staggered", c0, n_close);
        wb_xfer(1'b1, REG_CFG, 32'h0000_0441);
        wait_cyc(40);
        chk("close pulse after delay", c0 + 1, n_close);
        wait_cyc(12);
        chk("gate closed", 32'h1, {31'h0, at_closed});
        wb_xfer(1'b0, REG_CYCLES, 32'h0);
        chk("cycle count", 32'h1, rd);
        mains_ok <= 1'b1;
        batt_low <= 1'b0;
        wait_cyc(10);
        chk("normal after recovery", 32'h0, {31'h0, gate_out.halted});
        $display("test_fail_secure done");
    endtask

    task automatic test_service_clear();
        wb_xfer(1'b0, REG_SERVICE, 32'h0);
        chk("service count", 32'h1, rd);
        wb_xfer(1'b1, REG_CMD, 32'h0000_0002);
        wb_xfer(1'b0, REG_SERVICE, 32'h0);
        chk("service cleared", 32'h0, rd);
        wb_xfer(1'b0, REG_CYCLES, 32'h0);
        chk("total kept", 32'h1, rd);
        $display("test_service_clear done");
    endtask

    task automatic test_count_clear();
        logic seen;
        seen = 1'b0;
        wb_xfer(1'b1, REG_CMD, 32'h0000_0004);
        repeat (12) begin
            wb_xfer(1'b0, REG_DIGITS, 32'h0);
            if (rd === 32'h0000_0001) seen = 1'b1;
        end
        chk("count digits shown", 32'h1, {31'h0, seen});
        confirm_key <= 1'b1;
        wait_cyc(20);
        confirm_key <= 1'b0;
        wb_xfer(1'b0, REG_CYCLES, 32'h0);
        chk("count cleared by key", 32'h0, rd);
        wb_xfer(1'b0, REG_STATUS, 32'h0);
        chk("service flag after clear", 32'h0, {31'h0, rd[4]});
        chk("service indicator", 32'h0, {31'h0, gate_out.service_due_indicator});
        $display("test_count_clear done");
    endtask

    task automatic test_loop();
        int c0, c1;
        c0 = n_open;
        c1 = n_close;
        wb_xfer(1'b1, REG_CFG, 32'h0000_0140);
        wait_cyc(2);
        chk("ramp at closed limit", 32'h1, {31'h0, gate_out.ramp_active});
        open_hold <= 1'b1;
        wait_cyc(30);
        chk("loop opens arm", c0 + 1, n_open);
        chk("arm open", 32'h1, {31'h0, at_open});
        open_hold <= 1'b0;
        wait_cyc(8);
        exit_loop <= 1'b1;
        wait_cyc(12);
        exit_loop <= 1'b0;
        chk("presence end closes", c1 + 1, n_close);
        chk("exit loop stops arm", 32'h1, n_stop);
        chk("arm halted mid travel", 32'h0, {30'h0, at_closed, closing});
        chk("no ramp mid travel", 32'h0, {31'h0, gate_out.ramp_active});
        $display("test_loop done");
    endtask

    task automatic test_paired();
        int c0;
        c0 = n_partner;
        wb_xfer(1'b1, REG_CFG, 32'h0000_0640);
        @(posedge sys_clk);
        local_act <= 1'b1;
        wait_cyc(8);
        local_act <= 1'b0;
        wait_cyc(8);
        chk("partner signalled", c0 + 1, n_partner);
        $display("test_paired done");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        wait_cyc(5);
        sys_rst <= 1'b0;
        test_regs();
        test_open_now();
        test_fail_secure();
        test_service_clear();
        test_count_clear();
        test_loop();
        test_paired();
        print_verdict();
    end

    // the tests need well under a thousand cycles
    initial begin
        wait_cyc(20000);
        fails++;
        print_verdict();
    end
endmodule
`default_nettype wire
